//--- src/dpm_parity_bypass.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_parity_bypass (
  input wire logic core_clk,
  input wire logic sys_rst,
  // memory access request from cpu or card side
  input wire dpm_pkg::dpm_req_type memReq,
  output logic [31:0] memRdata,
  output logic memDone,
  // reporting to the requester
  output logic cpuFault_n,
  output logic cpuParErr_n,
  output logic cardFault_n,
  output logic cardParErr_n,
  // bypass path
  input wire logic io_chip_select_request_n,
  input wire dpm_pkg::dpm_bypass_type cpuBypass,
  output dpm_pkg::dpm_bypass_type ioBypass,
  input wire logic [15:0] ioBypassRdata,
  output logic [15:0] cpuBypassRdata,
  // peripheral pass sequencing
  input wire logic port_width_select,
  input wire logic lane_strobe_a_n,
  input wire logic lane_strobe_b_n,
  input wire logic xferStart,
  input wire logic [31:0] xferWord,
  output logic [15:0] ioLaneData,
  output logic [1:0] passAddr,
  output logic passValid,
  output logic xferBusy,
  output logic strobeIllegal
);
  // byte lane select: byte n sits at bits (31-8n) downto (24-8n)
  function automatic logic [7:0] byteOf(input logic [31:0] w, input logic [1:0] n);
    byteOf = w[8'(8'(31) - {n, 3'h0}) -: 8];
  endfunction : byteOf

  // memory array, kept untouched during bypass
  logic memAccess;
  logic [3:0] wparGen;
  logic [31:0] rdata;
  logic [3:0] rpar;
  logic [3:0] parCalc;
  assign memAccess = memReq.valid && io_chip_select_request_n;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_par
      assign wparGen[g] = ^memReq.wdata[g*8 +: 8];
      assign parCalc[g] = ^rdata[g*8 +: 8];
    end
  endgenerate

  dpm_word_mem u_mem (
    .core_clk(core_clk),
    .wrEn(memAccess && memReq.write),
    .laneEn(4'hF),
    .addr(memReq.addr[9:2]),
    .wdata(memReq.wdata),
    .wpar(wparGen),
    .rdata(rdata),
    .rpar(rpar)
  );

  // read tracking: data and parity appear one cycle after the request
  logic rdPend_reg;
  logic rdCard_reg;
  logic badPar;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdPend_reg <= 1'b0;
      rdCard_reg <= 1'b0;
    end else begin
      rdPend_reg <= memAccess && !memReq.write;
      rdCard_reg <= memReq.fromCard;
    end
  end
  assign badPar = rdPend_reg && (parCalc != rpar);
  assign memRdata = rdata;
  assign memDone = rdPend_reg;

  // fault lows toward whichever side made the read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpuFault_n <= 1'b1;
      cpuParErr_n <= 1'b1;
      cardFault_n <= 1'b1;
      cardParErr_n <= 1'b1;
    end else begin
      cpuFault_n <= !(badPar && !rdCard_reg);
      cpuParErr_n <= !(badPar && !rdCard_reg);
      cardFault_n <= !(badPar && rdCard_reg);
      cardParErr_n <= !(badPar && rdCard_reg);
    end
  end

  // bypass: straight registered forwarding, only while selected
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ioBypass <= '0;
      cpuBypassRdata <= 16'h0000;
    end else if (!io_chip_select_request_n) begin
      ioBypass.addr <= cpuBypass.addr;
      ioBypass.data <= cpuBypass.data;
      cpuBypassRdata <= ioBypassRdata;
    end
  end

  // pass sequencer for narrow peripherals
  dpm_pkg::dpm_state_type state_reg, state_next;
  logic [1:0] pass_reg, pass_next;
  logic width8_reg;
  logic [31:0] word_reg;
  logic lastPass;
  assign lastPass = pass_reg == (width8_reg ? dpm_pkg::PASSES_8BIT : dpm_pkg::PASSES_16BIT);

  always_comb begin
    state_next = state_reg;
    pass_next = pass_reg;
    case (state_reg)
      dpm_pkg::DPM_IDLE: begin
        pass_next = dpm_pkg::PASS_RST;
        if (xferStart) begin
          state_next = dpm_pkg::DPM_MOVE;
        end
      end
      dpm_pkg::DPM_MOVE: begin
        pass_next = 2'(pass_reg + 2'h1);
        if (lastPass) begin
          state_next = dpm_pkg::DPM_DONE;
        end
      end
      dpm_pkg::DPM_DONE: begin
        state_next = dpm_pkg::DPM_IDLE;
      end
      default: begin
        state_next = dpm_pkg::DPM_IDLE;
      end
    endcase
  end

  // width and word captured at start so a pass never mixes modes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= dpm_pkg::DPM_IDLE;
      pass_reg <= dpm_pkg::PASS_RST;
      width8_reg <= 1'b0;
      word_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      pass_reg <= pass_next;
      if (state_reg == dpm_pkg::DPM_IDLE && xferStart) begin
        width8_reg <= port_width_select == dpm_pkg::WIDTH_8;
        word_reg <= xferWord;
      end
    end
  end

  // pass address: 16-bit steps bit one only, bit zero held low
  logic [1:0] passA;
  logic [15:0] laneNext;
  assign passA = width8_reg ? pass_reg : {pass_reg[0], 1'b0};
  assign laneNext = width8_reg ?
    {8'h00, byteOf(word_reg, passA)} :
    {byteOf(word_reg, passA), byteOf(word_reg, 2'(passA + 2'h1))};
  assign passValid = state_reg == dpm_pkg::DPM_MOVE;
  assign xferBusy = state_reg != dpm_pkg::DPM_IDLE;

  // lane data registered for a clean io drive
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ioLaneData <= 16'h0000;
      passAddr <= 2'h0;
    end else begin
      ioLaneData <= passValid ? laneNext : 16'h0000;
      passAddr <= passValid ? passA : 2'h0;
    end
  end

  // both strobes negated (high) in 16-bit mode selects no byte: not legal
  assign strobeIllegal = (port_width_select == dpm_pkg::WIDTH_16) &&
    lane_strobe_a_n && lane_strobe_b_n;

  property p_par_report;
    @(posedge core_clk) disable iff (sys_rst)
      badPar |=> (cpuParErr_n == $past(rdCard_reg)) && (cardParErr_n == !$past(rdCard_reg)) &&
        (cpuFault_n == cpuParErr_n) && (cardFault_n == cardParErr_n);
  endproperty
  a_par_report: assert property (p_par_report) else $error("parity fault not reported");

  // no fault low may appear without a bad read behind it
  property p_par_quiet;
    @(posedge core_clk) disable iff (sys_rst)
      !badPar |=> cpuFault_n && cpuParErr_n && cardFault_n && cardParErr_n;
  endproperty
  a_par_quiet: assert property (p_par_quiet) else $error("fault low without bad parity");

  property p_no_write_check;
    @(posedge core_clk) disable iff (sys_rst)
      (memReq.valid && memReq.write) |=> ##1 (cpuParErr_n && cardParErr_n);
  endproperty
  a_no_write_check: assert property (p_no_write_check) else $error("write reported parity");

  property p_bypass_fwd;
    @(posedge core_clk) disable iff (sys_rst)
      !io_chip_select_request_n |=> ioBypass.addr == $past(cpuBypass.addr);
  endproperty
  a_bypass_fwd: assert property (p_bypass_fwd) else $error("bypass address lost");

  property p_bypass_nomem;
    @(posedge core_clk) disable iff (sys_rst)
      !io_chip_select_request_n |=> !rdPend_reg;
  endproperty
  a_bypass_nomem: assert property (p_bypass_nomem) else $error("bypass touched memory");

  sequence s_start8;
    state_reg == dpm_pkg::DPM_IDLE && xferStart && port_width_select;
  endsequence
  property p_four_pass;
    @(posedge core_clk) disable iff (sys_rst)
      s_start8 |=> passValid [*4] ##1 !passValid;
  endproperty
  a_four_pass: assert property (p_four_pass) else $error("8-bit not four passes");

  sequence s_start16;
    state_reg == dpm_pkg::DPM_IDLE && xferStart && !port_width_select;
  endsequence
  property p_two_pass;
    @(posedge core_clk) disable iff (sys_rst)
      s_start16 |=> passValid [*2] ##1 !passValid;
  endproperty
  a_two_pass: assert property (p_two_pass) else $error("16-bit not two passes");

  property p_half_bit0;
    @(posedge core_clk) disable iff (sys_rst)
      (passValid && !width8_reg) |-> !passA[0];
  endproperty
  a_half_bit0: assert property (p_half_bit0) else $error("bit zero used in 16-bit");

  property p_byte0_lane;
    @(posedge core_clk) disable iff (sys_rst)
      (passValid && width8_reg && passA == 2'h0) |=> ioLaneData[7:0] == $past(word_reg[31:24]);
  endproperty
  a_byte0_lane: assert property (p_byte0_lane) else $error("byte 0 misplaced");
endmodule : dpm_parity_bypass
`default_nettype wire

//--- src/dpm_pkg.sv
`default_nettype none
package dpm_pkg;
  // path widths
  localparam int WORD_W = 32;
  localparam int LANES = 4;
  localparam int BYP_ADDR_W = 24;
  localparam int BYP_DATA_W = 16;
  localparam int IO_W = 16;
  localparam int PASS_W = 2;
  // last pass index for a whole word (one less than the pass count)
  localparam logic [1:0] PASSES_8BIT = 2'h3;
  localparam logic [1:0] PASSES_16BIT = 2'h1;
  // port width select levels from the peripheral
  localparam logic WIDTH_16 = 1'h0;
  localparam logic WIDTH_8 = 1'h1;
  // reset values
  localparam logic [1:0] PASS_RST = 2'h0;
  localparam logic [3:0] PAR_RST = 4'h0;

  typedef enum logic [1:0] {
    DPM_IDLE = 2'h0,
    DPM_MOVE = 2'h1,
    DPM_DONE = 2'h3
  } dpm_state_type;

  // one memory-side access request
  typedef struct packed {
    logic valid;
    logic write;
    logic fromCard;     // 1 = feature card / dma, 0 = cpu
    logic [31:0] addr;
    logic [31:0] wdata;
  } dpm_req_type;

  // bypass address/data carrier
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
  } dpm_bypass_type;
endpackage : dpm_pkg
`default_nettype wire

//--- src/dpm_word_mem.sv
`timescale 1ns/1ps
`default_nettype none
// word store with its four lane parity bits; read data registered
module dpm_word_mem (
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [3:0] laneEn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wpar,
  output logic [31:0] rdata,
  output logic [3:0] rpar
);
  // one byte array and one parity array per lane, so each lane process owns
  // its own storage; parity travels with its byte
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      logic [7:0] laneMem [0:255];
      logic laneParMem [0:255];
      always_ff @(posedge core_clk) begin
        if (wrEn && laneEn[i]) begin
          laneMem[addr] <= wdata[i*8 +: 8];
          laneParMem[addr] <= wpar[i];
        end
        rdata[i*8 +: 8] <= laneMem[addr];
        rpar[i] <= laneParMem[addr];
      end
    end
  endgenerate
endmodule : dpm_word_mem
`default_nettype wire

//--- verification/dpm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_far_model (
  input wire logic core_clk,
  input wire logic bypassReq,
  input wire logic cardSel,
  input wire logic cardWide,
  input wire dpm_pkg::dpm_bypass_type ioBypass,
  output logic io_chip_select_request_n,
  output logic port_width_select,
  output logic [15:0] ioBypassRdata
);
  logic widthLast_reg = 1'h0;
  logic [15:0] rdLast_reg = 16'h0;
  // decoder asks for bypass by pulling the select low
  assign io_chip_select_request_n = ~bypassReq;
  // released lines show the inverse of the last value, never a stale copy
  assign port_width_select = cardSel ? ~cardWide : ~widthLast_reg;
  assign ioBypassRdata = bypassReq ? (ioBypass.addr[15:0] ^ 16'hA5A5) : ~rdLast_reg;
  // remember what was last driven, so a released line shows its inverse
  always @(posedge core_clk) begin
    if (cardSel) begin
      widthLast_reg <= port_width_select;
    end
    if (bypassReq) begin
      rdLast_reg <= ioBypassRdata;
    end
  end
endmodule : dpm_far_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'h0;
  logic sysRst = 1'h1;
  dpm_pkg::dpm_req_type memReq = '0;
  dpm_pkg::dpm_bypass_type cpuBypass = '0, ioBypass;
  logic bypassReq = 1'h0, cardSel = 1'h0, cardWide = 1'h0, strA = 1'h0, strB = 1'h0;
  logic xferStart = 1'h0;
  logic csN, width, memDone, passValid, xferBusy, ill, cF, cP, kF, kP;
  logic [31:0] xferWord = '0, memRdata, rd;
  logic [15:0] ioRd, cpuRd, lane;
  logic [1:0] passAddr;
  int fail_count = 0, checked = 0;
  // free-running core clock, 8 ns
  initial forever #4 core_clk = ~core_clk;
  dpm_far_model far (.core_clk(core_clk), .bypassReq(bypassReq), .cardSel(cardSel),
    .cardWide(cardWide), .ioBypass(ioBypass), .io_chip_select_request_n(csN),
    .port_width_select(width), .ioBypassRdata(ioRd));
  dpm_parity_bypass dut (.core_clk(core_clk), .sys_rst(sysRst), .memReq(memReq),
    .memRdata(memRdata), .memDone(memDone), .cpuFault_n(cF), .cpuParErr_n(cP),
    .cardFault_n(kF), .cardParErr_n(kP), .io_chip_select_request_n(csN),
    .cpuBypass(cpuBypass), .ioBypass(ioBypass), .ioBypassRdata(ioRd),
    .cpuBypassRdata(cpuRd), .port_width_select(width), .lane_strobe_a_n(strA),
    .lane_strobe_b_n(strB), .xferStart(xferStart), .xferWord(xferWord),
    .ioLaneData(lane), .passAddr(passAddr), .passValid(passValid), .xferBusy(xferBusy),
    .strobeIllegal(ill));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // one access; done may be absent if refused, so rd stays unknown then
  task automatic memOp(input logic wr, input logic card, input logic [7:0] a,
      input logic [31:0] d);
    rd = 'x;
    @(posedge core_clk) memReq <= {1'h1, wr, card, 22'h0, a, 2'h0, d};
    @(posedge core_clk) memReq.valid <= 1'h0;
    repeat (3) begin
      #1;
      if (memDone === 1'h1) rd = memRdata;
      chk({28'h0, cF, cP, kF, kP}, 32'hF);
      @(posedge core_clk);
    end
  endtask : memOp
  task automatic memTest;
    memOp(1'h1, 1'h0, 8'h04, 32'h12345678);
    memOp(1'h1, 1'h1, 8'h05, 32'hA5C30F81);
    memOp(1'h0, 1'h0, 8'h04, 32'h0);
    chk(rd, 32'h12345678);
    memOp(1'h0, 1'h1, 8'h05, 32'h0);
    chk(rd, 32'hA5C30F81);
    $display("memory test done");
  endtask : memTest
  // write under bypass must not reach memory
  task automatic bypTest;
    @(posedge core_clk);
    bypassReq <= 1'h1;
    cpuBypass <= {24'hABCDEF, 16'h1357};
    repeat (2) @(posedge core_clk);
    #1;
    chk({8'h0, ioBypass.addr}, 32'hABCDEF);
    chk({16'h0, ioBypass.data}, 32'h1357);
    chk({16'h0, cpuRd}, {16'h0, 16'hCDEF ^ 16'hA5A5});
    memOp(1'h1, 1'h0, 8'h04, 32'hDEADBEEF);
    @(posedge core_clk);
    bypassReq <= 1'h0;
    memOp(1'h0, 1'h0, 8'h04, 32'h0);
    chk(rd, 32'h12345678);
    $display("bypass test done");
  endtask : bypTest
  // a second start in mid-word is fed a different word and must be ignored
  task automatic passRun(input logic wide, input int n, input logic [31:0] w);
    int t;
    @(posedge core_clk);
    cardSel <= 1'h1;
    cardWide <= wide;
    xferStart <= 1'h1;
    xferWord <= w;
    @(posedge core_clk);
    xferStart <= 1'h0;
    #1;
    for (t = 0; t < 4 && passValid !== 1'h1; t++) @(posedge core_clk);
    for (int k = 0; k < n; k++) begin
      chk({31'h0, passValid}, 32'h1);
      @(posedge core_clk);
      xferStart <= (k == 0);
      xferWord <= ~w;
      #1;
      chk({16'h0, lane}, wide ? {16'h0, w[31-16*k -: 16]} : {24'h0, w[31-8*k -: 8]});
      chk({30'h0, passAddr}, wide ? 32'(2 * k) : 32'(k));
    end
    chk({31'h0, passValid}, 32'h0);
    chk({31'h0, xferBusy}, 32'h1);
    @(posedge core_clk);
    cardSel <= 1'h0;
    #1;
    chk({31'h0, xferBusy}, 32'h0);
    repeat (3) @(posedge core_clk);
    $display("pass test done, %0d passes", n);
  endtask : passRun
  // both strobes negated is illegal in 16-bit mode only
  task automatic illTest;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      cardSel <= 1'h1;
      cardWide <= i[2];
      strA <= i[1];
      strB <= i[0];
      @(posedge core_clk);
      #1;
      chk({31'h0, ill}, {31'h0, i == 7});
    end
    $display("strobe test done");
  endtask : illTest
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    sysRst <= 1'h0;
    memTest();
    bypTest();
    passRun(1'h0, 4, 32'h11223344);
    passRun(1'h1, 2, 32'hA1B2C3D4);
    illTest();
    print_verdict();
  end
  // watchdog, far beyond the fewer than a hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
